// ==== include/sfp_pkg.sv ====
package sfp_pkg;

  // ----------------------------------------------------------------
  // Array and framing
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W    = 18;
  localparam logic [2:0]  BIT_LAST  = 3'd7;
  localparam logic [1:0]  ABYTE_LST = 2'd2;

  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_LATCH_SET = 8'h06;
  localparam logic [7:0] OP_LATCH_CLR = 8'h04;
  localparam logic [7:0] OP_SR_RD     = 8'h05;
  localparam logic [7:0] OP_SR_WR     = 8'h01;
  localparam logic [7:0] OP_RD        = 8'h03;
  localparam logic [7:0] OP_FAST      = 8'h0b;
  localparam logic [7:0] OP_WR        = 8'h02;

  // ----------------------------------------------------------------
  // Status register layout and reset values
  // ----------------------------------------------------------------
  localparam int unsigned SR_HWPE_BIT = 7;
  localparam int unsigned SR_BGH_BIT  = 3;
  localparam int unsigned SR_BGL_BIT  = 2;
  localparam int unsigned SR_WLF_BIT  = 1;
  localparam logic [7:0]  SR_FIXED    = 8'h40;
  localparam logic [1:0]  BG_RST      = 2'h0;
  localparam logic        HWPE_RST    = 1'b0;
  localparam logic        WLF_RST     = 1'b0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
    logic wp_n;
  } sfp_pins_t;

  localparam sfp_pins_t PINS_IDLE = '{cs_n: 1'b1, sck: 1'b0,
                                      si: 1'b0, wp_n: 1'b1};

  typedef enum logic [3:0] {
    ST_OPC, ST_ADDR, ST_DUMMY, ST_WDATA, ST_RDATA,
    ST_SRD, ST_SWR, ST_IGNORE
  } sfp_state_t;

endpackage : sfp_pkg

// ==== rtl/sfp_fram_spi.sv ====
//------------------------------------------------------------------
// SPI nonvolatile memory slave with status register protection
//------------------------------------------------------------------
// Function
// - Status: bit7 hw protect, bit3/2 guard, bit1 latch; 0,4,5 zero, 6 one
// - Latch zero at power-up, set only by set command, never by write
// - Guard 00 none, 01 30000h up, 10 20000h up, 11 whole array
// - Guard bits are nonvolatile and survive reset
// - Status locked only when hw protect set and guard pin low
// - Array write needs latch set and address outside guard range
// - Status read opcode returns status byte MSB first
// - Status write updates protect and guard bits, then clears latch
// - Write: own latch-set cycle, then opcode plus three address bytes
// - Write burst increments address, wraps 3FFFFh to 00000h
// - Each byte stored at its eighth bit; partial byte dropped
// - Burst hitting guarded address stops address and drops bytes
// - Read streams bytes MSB first from incrementing wrapping address
// - Chip select rising ends read and floats serial out
// - Fast read adds a dummy byte, then streams like read
// - Fast read ignores serial in while streaming until deselect
// - Opcodes 06h set, 04h clear, 05h status read, first byte only
// - Opcodes 01h status write, 03h read, 02h write, one per select
// - Sample serial in on rising clock, drive out on falling
// - Unknown opcode: ignore rest of select, keep output floating
module sfp_fram_spi
  import sfp_pkg::*;
#(
  parameter int unsigned AW = ADDR_W
) (
  // Clock and reset
  input  wire logic CLK_IN,
  input  wire logic RST_IN,
  // Serial link from the master
  input  wire logic CS_N_IN,
  input  wire logic SCK_IN,
  input  wire logic SI_IN,
  input  wire logic WP_N_IN,
  // Serial out, two signals of a tristate pin
  output logic      SO_OUT,
  output logic      SO_OE_N_OUT
);

  //----------------------------------------------------------------
  // Decoding helpers
  //----------------------------------------------------------------
  // Guard range test, shared by the write path and its checks
  function automatic logic guard_hit(input logic [1:0]    bg,
                                     input logic [AW-1:0] a);
    case (bg)
      2'b01:   guard_hit = (a[AW-1:AW-2] == 2'b11);
      2'b10:   guard_hit = a[AW-1];
      2'b11:   guard_hit = 1'b1;
      default: guard_hit = 1'b0;
    endcase
  endfunction : guard_hit

  // Assemble the readable status byte around the fixed bits
  function automatic logic [7:0] status_of(input logic       hw,
                                           input logic [1:0] bg,
                                           input logic       wl);
    status_of             = SR_FIXED;
    status_of[SR_HWPE_BIT] = hw;
    status_of[SR_BGH_BIT] = bg[1];
    status_of[SR_BGL_BIT] = bg[0];
    status_of[SR_WLF_BIT] = wl;
  endfunction : status_of

  //----------------------------------------------------------------
  // Pin synchronisers
  //----------------------------------------------------------------
  sfp_pins_t meta_ff;
  sfp_pins_t pin_ff;
  sfp_pins_t prev_ff;

  // Two flops per pin, then one more stage for edge finding
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      meta_ff <= PINS_IDLE;
      pin_ff  <= PINS_IDLE;
      prev_ff <= PINS_IDLE;
    end else begin
      meta_ff <= '{cs_n: CS_N_IN, sck: SCK_IN, si: SI_IN, wp_n: WP_N_IN};
      pin_ff  <= meta_ff;
      prev_ff <= pin_ff;
    end
  end

  logic sck_rise;
  logic sck_fall;
  logic cs_rise;

  // Mode 0 idles low, so selection itself never looks like a rise
  assign sck_rise = pin_ff.sck & ~prev_ff.sck & ~pin_ff.cs_n;
  assign sck_fall = ~pin_ff.sck & prev_ff.sck & ~pin_ff.cs_n;
  assign cs_rise  = ~prev_ff.cs_n & pin_ff.cs_n;

  //----------------------------------------------------------------
  // Storage
  //----------------------------------------------------------------
  logic [7:0]    mem [2**AW];
  logic          mem_we;
  logic [7:0]    rx_byte;
  sfp_state_t    state_ff,  nxt_state;
  logic [2:0]    bit_ff,    nxt_bit;
  logic [1:0]    abyte_ff,  nxt_abyte;
  logic [7:0]    sh_ff,     nxt_sh;
  logic [7:0]    op_ff,     nxt_op;
  logic [7:0]    tx_ff,     nxt_tx;
  logic [AW-1:0] addr_ff,   nxt_addr;
  logic          stop_ff,   nxt_stop;
  logic          clr_ff,    nxt_clr;
  logic          wel_ff,    nxt_wel;
  logic          hw_protect_enable_ff,   nxt_hw_protect_enable;
  logic          so_ff,     nxt_so;
  logic          oe_n_ff,   nxt_oe_n;
  logic          sr_we;
  logic          sr_lock;
  logic [1:0]    bg_ff = BG_RST;
  logic [1:0]    nxt_bg;
  logic [7:0]    status;

  assign rx_byte = {sh_ff[6:0], pin_ff.si};
  assign status  = status_of(hw_protect_enable_ff, bg_ff, wel_ff);
  // Guard pin counts only when hardware protection is enabled
  assign sr_lock = hw_protect_enable_ff & ~pin_ff.wp_n;

  //----------------------------------------------------------------
  // Command engine, next state
  //----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_bit   = bit_ff;
    nxt_abyte = abyte_ff;
    nxt_sh    = sh_ff;
    nxt_op    = op_ff;
    nxt_tx    = tx_ff;
    nxt_addr  = addr_ff;
    nxt_stop  = stop_ff;
    nxt_clr   = clr_ff;
    nxt_wel   = wel_ff;
    nxt_hw_protect_enable  = hw_protect_enable_ff;
    nxt_so    = so_ff;
    nxt_oe_n  = oe_n_ff;
    mem_we    = 1'b0;
    sr_we     = 1'b0;
    if (pin_ff.cs_n) begin
      // Deselect ends every command and floats the output
      nxt_state = ST_OPC;
      nxt_bit   = 3'd0;
      nxt_stop  = 1'b0;
      nxt_clr   = 1'b0;
      nxt_oe_n  = 1'b1;
      nxt_so    = 1'b0;
      if (cs_rise && clr_ff) begin
        nxt_wel = 1'b0;
      end
    end else if (sck_rise) begin
      nxt_sh  = rx_byte;
      nxt_bit = bit_ff + 3'd1;
      if (bit_ff == BIT_LAST) begin
        case (state_ff)
          ST_OPC: begin
            nxt_op    = rx_byte;
            nxt_abyte = 2'd0;
            case (rx_byte)
              OP_LATCH_SET: begin
                nxt_wel   = 1'b1;
                nxt_state = ST_IGNORE;
              end
              OP_LATCH_CLR: begin
                nxt_clr   = 1'b1;
                nxt_state = ST_IGNORE;
              end
              OP_SR_RD: begin
                nxt_tx    = status;
                nxt_state = ST_SRD;
              end
              OP_SR_WR: begin
                nxt_clr   = 1'b1;
                nxt_state = ST_SWR;
              end
              OP_WR: begin
                nxt_clr   = 1'b1;
                nxt_state = ST_ADDR;
              end
              OP_RD, OP_FAST: begin
                nxt_state = ST_ADDR;
              end
              default: begin
                nxt_state = ST_IGNORE;
              end
            endcase
          end
          ST_ADDR: begin
            // Upper six bits fall off the top of the counter
            nxt_addr  = AW'({addr_ff, rx_byte});
            nxt_abyte = abyte_ff + 2'd1;
            if (abyte_ff == ABYTE_LST) begin
              case (op_ff)
                OP_WR: nxt_state = ST_WDATA;
                OP_FAST: nxt_state = ST_DUMMY;
                default: begin
                  nxt_tx    = mem[nxt_addr];
                  nxt_state = ST_RDATA;
                end
              endcase
            end
          end
          ST_DUMMY: begin
            nxt_tx    = mem[addr_ff];
            nxt_state = ST_RDATA;
          end
          ST_RDATA: begin
            // Serial in is ignored here, only the clock matters
            nxt_addr = addr_ff + AW'(1);
            nxt_tx   = mem[nxt_addr];
          end
          ST_SRD: begin
            nxt_tx = status;
          end
          ST_SWR: begin
            // Latch bit in the written byte is never taken
            if (wel_ff && !sr_lock) begin
              sr_we    = 1'b1;
              nxt_hw_protect_enable = rx_byte[SR_HWPE_BIT];
            end
            nxt_state = ST_IGNORE;
          end
          ST_WDATA: begin
            if (!stop_ff) begin
              if (guard_hit(bg_ff, addr_ff)) begin
                nxt_stop = 1'b1;
              end else begin
                mem_we   = wel_ff;
                nxt_addr = addr_ff + AW'(1);
              end
            end
          end
          default: begin
            nxt_state = state_ff;
          end
        endcase
      end
    end else if (sck_fall &&
                 (state_ff == ST_RDATA || state_ff == ST_SRD)) begin
      // Output changes on the falling edge, MSB first
      nxt_so   = tx_ff[7];
      nxt_tx   = {tx_ff[6:0], 1'b0};
      nxt_oe_n = 1'b0;
    end
  end

  // Command engine registers
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      state_ff <= ST_OPC;
      bit_ff   <= 3'd0;
      abyte_ff <= 2'd0;
      sh_ff    <= 8'h00;
      op_ff    <= 8'h00;
      tx_ff    <= 8'h00;
      addr_ff  <= '0;
      stop_ff  <= 1'b0;
      clr_ff   <= 1'b0;
      wel_ff   <= WLF_RST;
      hw_protect_enable_ff  <= HWPE_RST;
      so_ff    <= 1'b0;
      oe_n_ff  <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      bit_ff   <= nxt_bit;
      abyte_ff <= nxt_abyte;
      sh_ff    <= nxt_sh;
      op_ff    <= nxt_op;
      tx_ff    <= nxt_tx;
      addr_ff  <= nxt_addr;
      stop_ff  <= nxt_stop;
      clr_ff   <= nxt_clr;
      wel_ff   <= nxt_wel;
      hw_protect_enable_ff  <= nxt_hw_protect_enable;
      so_ff    <= nxt_so;
      oe_n_ff  <= nxt_oe_n;
    end
  end

  //----------------------------------------------------------------
  // Nonvolatile guard bits and array
  //----------------------------------------------------------------
  // No reset on purpose: these model cells that keep their value
  always_comb begin
    nxt_bg = bg_ff;
    if (sr_we) begin
      nxt_bg = {rx_byte[SR_BGH_BIT], rx_byte[SR_BGL_BIT]};
    end
  end

  always_ff @(posedge CLK_IN) begin
    bg_ff <= nxt_bg;
  end

  // Byte lands at once, no page buffer to lose on deselect
  always_ff @(posedge CLK_IN) begin
    if (mem_we) begin
      mem[addr_ff] <= rx_byte;
    end
  end

  assign SO_OUT      = so_ff;
  assign SO_OE_N_OUT = oe_n_ff;

  //----------------------------------------------------------------
  // Checks
  //----------------------------------------------------------------
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);

  status_fixed_a: assert property (
    status[6] && status[5:4] == 2'b00 && !status[0])
    else $error("status fixed bits wrong");

  latch_set_a: assert property (
    sck_rise && state_ff == ST_OPC && bit_ff == BIT_LAST &&
    rx_byte == OP_LATCH_SET |=> wel_ff)
    else $error("latch not set by set command");

  latch_clear_a: assert property (
    cs_rise && clr_ff |=> !wel_ff)
    else $error("latch not cleared at deselect");

  array_guard_a: assert property (
    mem_we |-> wel_ff && !guard_hit(bg_ff, addr_ff))
    else $error("array write in guarded range or without latch");

  status_lock_a: assert property (
    sr_we |-> wel_ff && !(hw_protect_enable_ff && !pin_ff.wp_n))
    else $error("status written while locked");

  addr_wrap_a: assert property (
    mem_we && addr_ff == '1 |=> addr_ff == '0)
    else $error("write address did not wrap");

  guard_stop_a: assert property (
    stop_ff && !pin_ff.cs_n |=> $stable(addr_ff) && !mem_we)
    else $error("burst advanced past guarded address");

  so_float_a: assert property (
    pin_ff.cs_n |=> SO_OE_N_OUT ##1 SO_OE_N_OUT)
    else $error("serial out driven while deselected");

  ignore_hold_a: assert property (
    state_ff == ST_IGNORE && !pin_ff.cs_n |=>
    state_ff == ST_IGNORE && SO_OE_N_OUT)
    else $error("ignored command resumed");

  wr_byte_c: cover property (mem_we);
  sr_write_c: cover property (sr_we);
  fast_out_c: cover property (
    op_ff == OP_FAST && state_ff == ST_RDATA && sck_fall);
  stop_c: cover property ($rose(stop_ff));

endmodule : sfp_fram_spi

// ==== verif/sfp_spi_master.sv ====
module sfp_spi_master
  import sfp_pkg::*;
(
  // Clock and returned serial data
  input  wire logic clk_in,
  input  wire logic so_in,
  // Pins toward the device
  output sfp_pins_t pins_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Frame and bit tasks, mode 0 so the link clock idles low
  // ----------------------------------------------------------------
  initial begin
    pins_out = PINS_IDLE;
  end

  // Select opens a frame; setup left well above the sync delay
  task automatic sel();
    @(posedge clk_in);
    pins_out.cs_n <= 1'b0;
    repeat (5) @(posedge clk_in);
  endtask : sel

  // Deselect closes the frame, one opcode per select
  task automatic desel();
    repeat (5) @(posedge clk_in);
    pins_out.cs_n <= 1'b1;
    repeat (10) @(posedge clk_in);
  endtask : desel

  // Low 6 cycles, high 4: 80 ns; reply read just before the rise
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      pins_out.si <= tx[i];
      repeat (6) @(posedge clk_in);
      rx[i] = so_in;
      pins_out.sck <= 1'b1;
      repeat (4) @(posedge clk_in);
      pins_out.sck <= 1'b0;
    end
  endtask : xfer

  // Write guard pin level
  task automatic guard(input logic lvl);
    @(posedge clk_in);
    pins_out.wp_n <= lvl;
  endtask : guard
endmodule : sfp_spi_master

// ==== verif/tb_sfp_fram_spi.sv ====
module tb_sfp_fram_spi;
  import sfp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Harness
  // ----------------------------------------------------------------
  logic      clk;
  logic      rst;
  sfp_pins_t pins;
  logic      so;
  logic      so_oe_n;
  logic      so_line;
  logic      float_ff = 1'b0;
  logic      watch    = 1'b0;
  logic      oe_bad   = 1'b0;
  int        n_checks = 0;
  int        mismatches = 0;
  logic [7:0] v;
  logic       hit;
  logic [7:0] mem [1:3];

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Released line toggles so a stale level can never pass as data
  always @(posedge clk) float_ff <= ~float_ff;
  assign so_line = so_oe_n ? float_ff : so;

  // Output must stay floated while an unknown opcode is ignored
  always @(posedge clk) begin
    if (watch && so_oe_n !== 1'b1) begin
      oe_bad <= 1'b1;
    end
  end

  sfp_fram_spi #(.AW(18)) sfp_fram_spi_inst (
    .CLK_IN      (clk),
    .RST_IN      (rst),
    .CS_N_IN     (pins.cs_n),
    .SCK_IN      (pins.sck),
    .SI_IN       (pins.si),
    .WP_N_IN     (pins.wp_n),
    .SO_OUT      (so),
    .SO_OE_N_OUT (so_oe_n)
  );

  sfp_spi_master sfp_spi_master_inst (
    .clk_in   (clk),
    .so_in    (so_line),
    .pins_out (pins)
  );

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test

  task automatic op1(input logic [7:0] op);
    logic [7:0] r;
    sfp_spi_master_inst.sel();
    sfp_spi_master_inst.xfer(op, r);
    sfp_spi_master_inst.desel();
  endtask : op1

  task automatic srd(input logic [7:0] exp);
    logic [7:0] r;
    sfp_spi_master_inst.sel();
    sfp_spi_master_inst.xfer(OP_SR_RD, r);
    sfp_spi_master_inst.xfer(8'h00, r);
    sfp_spi_master_inst.desel();
    chk(r, exp);
  endtask : srd

  task automatic swr(input logic lat, input logic [7:0] val);
    logic [7:0] r;
    if (lat) op1(OP_LATCH_SET);
    sfp_spi_master_inst.sel();
    sfp_spi_master_inst.xfer(OP_SR_WR, r);
    sfp_spi_master_inst.xfer(val, r);
    sfp_spi_master_inst.desel();
  endtask : swr

  task automatic wr(input logic lat, input logic [23:0] a,
                    input logic [7:0] d[$]);
    logic [7:0] r;
    if (lat) op1(OP_LATCH_SET);
    sfp_spi_master_inst.sel();
    sfp_spi_master_inst.xfer(OP_WR, r);
    for (int i = 2; i >= 0; i--) sfp_spi_master_inst.xfer(a[i*8+:8], r);
    foreach (d[i]) sfp_spi_master_inst.xfer(d[i], r);
    sfp_spi_master_inst.desel();
  endtask : wr

  // Serial in carries the inverse of the expected data, to be ignored
  task automatic rd(input logic [7:0] op, input logic [23:0] a,
                    input logic [7:0] e[$]);
    logic [7:0] r;
    sfp_spi_master_inst.sel();
    sfp_spi_master_inst.xfer(op, r);
    for (int i = 2; i >= 0; i--) sfp_spi_master_inst.xfer(a[i*8+:8], r);
    if (op == OP_FAST) sfp_spi_master_inst.xfer(8'h5a, r);
    foreach (e[i]) begin
      sfp_spi_master_inst.xfer(~e[i], r);
      chk(r, e[i]);
    end
    sfp_spi_master_inst.desel();
    chk({7'h0, so_oe_n}, 8'h01);
  endtask : rd

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
    srd(8'h40);
    swr(1'b0, 8'h8c);
    srd(8'h40);
    op1(OP_LATCH_SET);
    srd(8'h42);
    op1(OP_LATCH_CLR);
    srd(8'h40);
    // Guard code stays 00 here so the pin-low array write can land
    swr(1'b1, 8'hb3);
    srd(8'hc0);
    sfp_spi_master_inst.guard(1'b0);
    swr(1'b1, 8'h00);
    srd(8'hc0);
    wr(1'b1, 24'h000010, '{8'h77});
    rd(OP_RD, 24'h000010, '{8'h77});
    sfp_spi_master_inst.guard(1'b1);
    swr(1'b1, 8'h00);
    srd(8'h40);
    $display("test status done");
    wr(1'b1, 24'hff_ffff, '{8'ha5, 8'h5a});
    srd(8'h40);
    rd(OP_RD, 24'hc3_ffff, '{8'ha5, 8'h5a});
    wr(1'b0, 24'h000000, '{8'h11});
    rd(OP_RD, 24'h000000, '{8'h5a});
    rd(OP_FAST, 24'h03_ffff, '{8'ha5, 8'h5a});
    $display("test array done");
    // Each guard code against one address in each upper quarter
    for (int g = 0; g < 4; g++) begin
      swr(1'b1, {4'h0, g[1:0], 2'b00});
      for (int k = 1; k < 4; k++) begin
        v = {g[3:0], k[3:0]};
        hit = (g == 3) || (g == 2 && k > 1) || (g == 1 && k == 3);
        wr(1'b1, {6'h0, k[1:0], 16'hffff}, '{v});
        if (!hit) mem[k] = v;
        rd(OP_RD, {6'h0, k[1:0], 16'hffff}, '{mem[k]});
      end
    end
    swr(1'b1, 8'h00);
    wr(1'b1, 24'h02fffe, '{8'h11, 8'h22, 8'h33});
    swr(1'b1, 8'h04);
    wr(1'b1, 24'h02fffe, '{8'h44, 8'h55, 8'h66, 8'h77});
    rd(OP_RD, 24'h02fffe, '{8'h44, 8'h55, 8'h33});
    $display("test guard done");
    watch <= 1'b1;
    wr(1'b0, 24'h9f0000, '{8'h00});
    op1(8'h9f);
    watch <= 1'b0;
    chk({7'h0, oe_bad}, 8'h00);
    @(posedge clk);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
    srd(8'h44);
    $display("test misc done");
    finish_test();
  end

  // Bounded run: a hang counts as a mismatch
  initial begin
    repeat (90000) @(posedge clk);
    mismatches++;
    $display("BAD t=%0t run limit reached", $time);
    finish_test();
  end
endmodule : tb_sfp_fram_spi
